// >>> hdl/nas_pkg.sv
// Purpose: Shared constants and operation codes for the nibble ALU.
// Assumes: Operations arrive already decoded from the instruction sequencer.
// Notes:   Nibble widths follow the 4-bit core datapath; ROM words are 10 bits.
package nas_pkg;
    localparam int NIB_W        = 4;
    localparam int ROM_W        = 10;
    localparam int ROM_ADDR_W   = 7;
    localparam int TPTR_W       = 3;
    localparam logic [3:0] ACC_RST   = 4'h0;
    localparam logic [3:0] AUX_RST   = 4'h0;
    localparam logic [2:0] TPTR_RST  = 3'h0;
    localparam logic       CARRY_RST = 1'b0;
    // ROM word field positions and sum carry bit
    localparam int ROM_HI_LSB   = 8;
    localparam int ROM_AUX_LSB  = 4;
    localparam int ROM_ACC_LSB  = 0;
    localparam int CARRY_BIT    = 4;

    typedef enum logic [3:0] {
        NAS_OP_NONE,
        NAS_OP_LOAD_IMM,
        NAS_OP_TABLE,
        NAS_OP_ADD_MEM,
        NAS_OP_ADD_MEM_C,
        NAS_OP_ADD_IMM,
        NAS_OP_AND,
        NAS_OP_OR,
        NAS_OP_SET_C,
        NAS_OP_CLR_C,
        NAS_OP_SKIP_CZ,
        NAS_OP_CPL,
        NAS_OP_ROR,
        NAS_OP_SET_BIT,
        NAS_OP_CLR_BIT,
        NAS_OP_SKIP_BZ
    } nas_op_e;
endpackage

// >>> hdl/nas_alu_if.sv
// Purpose: Carries operands and results between the control and the ALU.
// Assumes: Purely combinational results.
// Notes:   ctl drives operands, alu returns results.
`timescale 1ns/10ps
interface nas_alu_if;
    nas_pkg::nas_op_e op;
    logic [3:0]       acc;
    logic [3:0]       mem;
    logic [3:0]       imm;
    logic             carry;
    logic [3:0]       acc_res;
    logic             carry_res;
    logic [3:0]       mem_res;
    logic             skip_res;
    modport ctl (output op, acc, mem, imm, carry,
                 input acc_res, carry_res, mem_res, skip_res);
    modport alu (input op, acc, mem, imm, carry,
                 output acc_res, carry_res, mem_res, skip_res);
endinterface

// >>> hdl/nas_alu.sv
// Purpose: Combinational nibble arithmetic, logic and bit operations.
// Assumes: Operands are stable for the whole cycle.
// Notes:   Overflow is the carry out of bit 3.
`timescale 1ns/10ps
module nas_alu (
    nas_alu_if.alu bus
);
    logic [4:0] sum_mem;
    logic [4:0] sum_memc;
    logic [4:0] sum_imm;
    logic [3:0] bit_mask;

    // Sums are one bit wider so the carry out of bit 3 is kept
    assign sum_mem  = {1'b0, bus.acc} + {1'b0, bus.mem};            // RULE20
    assign sum_memc = {1'b0, bus.acc} + {1'b0, bus.mem}
                      + {4'h0, bus.carry};
    assign sum_imm  = {1'b0, bus.acc} + {1'b0, bus.imm};
    assign bit_mask = 4'h1 << bus.imm[1:0];                          // RULE18

    // Result selection per operation
    always_comb begin
        bus.acc_res   = bus.acc;
        bus.carry_res = bus.carry;
        bus.mem_res   = bus.mem;
        bus.skip_res  = 1'b0;
        case (bus.op)
            nas_pkg::NAS_OP_LOAD_IMM:  bus.acc_res = bus.imm;        // RULE1
            nas_pkg::NAS_OP_ADD_MEM:   bus.acc_res = sum_mem[3:0];   // RULE6
            nas_pkg::NAS_OP_ADD_MEM_C: begin
                bus.acc_res   = sum_memc[3:0];                       // RULE7
                bus.carry_res = sum_memc[nas_pkg::CARRY_BIT];        // RULE7
            end
            nas_pkg::NAS_OP_ADD_IMM: begin
                bus.acc_res  = sum_imm[3:0];                         // RULE8
                bus.skip_res = ~sum_imm[nas_pkg::CARRY_BIT];         // RULE8
            end
            nas_pkg::NAS_OP_AND:    bus.acc_res = bus.acc & bus.mem; // RULE9
            nas_pkg::NAS_OP_OR:     bus.acc_res = bus.acc | bus.mem; // RULE10
            nas_pkg::NAS_OP_SET_C:  bus.carry_res = 1'b1;            // RULE11
            nas_pkg::NAS_OP_CLR_C:  bus.carry_res = 1'b0;            // RULE12
            nas_pkg::NAS_OP_SKIP_CZ: bus.skip_res = ~bus.carry;      // RULE13
            nas_pkg::NAS_OP_CPL:    bus.acc_res = ~bus.acc;          // RULE14
            nas_pkg::NAS_OP_ROR: begin
                bus.acc_res   = {bus.carry, bus.acc[3:1]};           // RULE15
                bus.carry_res = bus.acc[0];                          // RULE15
            end
            nas_pkg::NAS_OP_SET_BIT: bus.mem_res = bus.mem | bit_mask; // RULE16
            nas_pkg::NAS_OP_CLR_BIT: bus.mem_res = bus.mem & ~bit_mask; // RULE17
            nas_pkg::NAS_OP_SKIP_BZ:
                bus.skip_res = ((bus.mem & bit_mask) == 4'h0);       // RULE18
            default: ;
        endcase
    end
endmodule

// >>> hdl/nas_core.sv
// What this block does
// RULE1: load_immediate writes the immediate field into the accumulator.
// RULE2: Back-to-back load_immediate: only the first acts, the rest skip.
// RULE3: table_lookup reads ROM at page, pointer and accumulator; loads aux, acc.
// RULE4: With upper_table_flag set, ROM bits 9..8 go to pointer low, msb cleared.
// RULE5: table_lookup holds one stack_level while the lookup runs.
// RULE6: add_memory adds memory to accumulator, carry unchanged.
// RULE7: add_memory_carry adds memory and carry; carry out to carry_flag.
// RULE8: add_immediate adds operand, carry kept, skips when no overflow.
// RULE9: AND combines accumulator with memory into accumulator.
// RULE10: OR combines accumulator with memory into accumulator.
// RULE11: set_carry_op sets carry, accumulator untouched.
// RULE12: clear_carry_op clears carry, accumulator untouched.
// RULE13: skip_if_carry_zero skips when carry is zero; carry kept.
// RULE14: complement_acc inverts the accumulator.
// RULE15: rotate_right_carry rotates accumulator right through carry.
// RULE16: set_mem_bit sets the indexed memory bit only.
// RULE17: clear_mem_bit clears the indexed memory bit only.
// RULE18: skip_if_mem_bit_zero skips when indexed bit 0..3 is zero.
// RULE19: A skipped instruction changes no register, flag or memory.
// RULE20: Datapath is four bits; overflow is carry out of bit 3.
//
// Purpose: Execution datapath of the 4-bit core.
// Assumes: i_op_valid pulses once per instruction; ROM answers next cycle.
// Notes:   table_lookup takes three cycles and stalls via o_busy.
`timescale 1ns/10ps
module nas_core #(
    parameter int PAGE_W = 7
) (
    // Clock and reset
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    // Decoded instruction from sequencer
    input  wire logic                        i_op_valid,
    input  wire nas_pkg::nas_op_e            i_op,
    input  wire logic [3:0]                  i_imm,
    input  wire logic [PAGE_W-1:0]           i_page,
    input  wire logic                        i_upper_table_flag,
    // Data memory at pointer
    input  wire logic [3:0]                  i_mem_rdata,
    output logic      [3:0]                  o_mem_wdata,
    output logic                             o_mem_we,
    // Program ROM table port
    output logic      [PAGE_W+6:0]           o_rom_addr,
    output logic                             o_rom_re,
    input  wire logic [9:0]                  i_rom_data,
    // Return stack occupancy and stall
    output logic                             o_stack_push,
    output logic                             o_stack_pop,
    output logic                             o_busy,
    // Sequencer skip and visible state
    output logic                             o_skip,
    output logic      [3:0]                  o_acc,
    output logic      [3:0]                  o_aux,
    output logic                             o_carry,
    output logic      [2:0]                  o_table_ptr
);
    typedef enum logic [1:0] {
        NAS_ST_IDLE,
        NAS_ST_ROM,
        NAS_ST_LOAD
    } nas_st_e;

    nas_st_e     st_r;
    nas_st_e     st_nxt;
    logic [3:0]  acc_r;
    logic [3:0]  acc_nxt;
    logic [3:0]  aux_r;
    logic [3:0]  aux_nxt;
    logic [2:0]  tptr_r;
    logic [2:0]  tptr_nxt;
    logic        carry_r;
    logic        carry_nxt;
    logic        skip_pend_r;
    logic        prev_load_r;
    logic        upper_r;
    logic [PAGE_W+6:0] rom_addr_nxt;

    nas_alu_if alu_bus ();

    nas_alu u_alu (
        .bus (alu_bus)
    );

    wire logic executing = i_op_valid && (st_r == NAS_ST_IDLE);
    // Skipped slot: pending skip or a repeated load_immediate
    wire logic chain_load = (i_op == nas_pkg::NAS_OP_LOAD_IMM) && prev_load_r;
    wire logic suppress   = skip_pend_r || chain_load;            // RULE2
    wire logic active     = executing && !suppress;               // RULE19
    wire logic start_tbl  = active && (i_op == nas_pkg::NAS_OP_TABLE);

    // Operands to the ALU
    assign alu_bus.op    = active ? i_op : nas_pkg::NAS_OP_NONE;  // RULE19
    assign alu_bus.acc   = acc_r;
    assign alu_bus.mem   = i_mem_rdata;
    assign alu_bus.imm   = i_imm;
    assign alu_bus.carry = carry_r;

    // ROM address from page, pointer and accumulator
    assign rom_addr_nxt  = {i_page, tptr_r, acc_r};               // RULE3

    // Sequencer of the three-cycle table lookup
    always_comb begin
        st_nxt    = st_r;
        acc_nxt   = alu_bus.acc_res;
        aux_nxt   = aux_r;
        tptr_nxt  = tptr_r;
        carry_nxt = alu_bus.carry_res;
        case (st_r)
            NAS_ST_IDLE: if (start_tbl) st_nxt = NAS_ST_ROM;
            NAS_ST_ROM:  st_nxt = NAS_ST_LOAD;
            NAS_ST_LOAD: begin
                st_nxt  = NAS_ST_IDLE;
                aux_nxt = i_rom_data[nas_pkg::ROM_AUX_LSB +: 4];  // RULE3
                acc_nxt = i_rom_data[nas_pkg::ROM_ACC_LSB +: 4];  // RULE3
                if (upper_r) begin
                    tptr_nxt = {1'b0,
                        i_rom_data[nas_pkg::ROM_HI_LSB +: 2]};    // RULE4
                end
            end
            default: st_nxt = NAS_ST_IDLE;
        endcase
    end

    // Architectural state
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r    <= NAS_ST_IDLE;
            acc_r   <= nas_pkg::ACC_RST;
            aux_r   <= nas_pkg::AUX_RST;
            tptr_r  <= nas_pkg::TPTR_RST;
            carry_r <= nas_pkg::CARRY_RST;
        end else begin
            st_r    <= st_nxt;
            acc_r   <= acc_nxt;
            aux_r   <= aux_nxt;
            tptr_r  <= tptr_nxt;
            carry_r <= carry_nxt;
        end
    end

    // Skip and load-chain tracking; a skipped slot clears the pending skip
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            skip_pend_r <= 1'b0;
            prev_load_r <= 1'b0;
            upper_r     <= 1'b0;
        end else if (executing) begin
            skip_pend_r <= active && alu_bus.skip_res;
            prev_load_r <= (i_op == nas_pkg::NAS_OP_LOAD_IMM);    // RULE2
            if (start_tbl) upper_r <= i_upper_table_flag;         // RULE4
        end
    end

    // Registered outputs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mem_wdata  <= 4'h0;
            o_mem_we     <= 1'b0;
            o_rom_addr   <= '0;
            o_rom_re     <= 1'b0;
            o_stack_push <= 1'b0;
            o_stack_pop  <= 1'b0;
            o_busy       <= 1'b0;
            o_skip       <= 1'b0;
        end else begin
            o_mem_wdata  <= alu_bus.mem_res;
            o_mem_we     <= active &&
                (i_op == nas_pkg::NAS_OP_SET_BIT ||
                 i_op == nas_pkg::NAS_OP_CLR_BIT);                // RULE16
            o_rom_addr   <= rom_addr_nxt;
            o_rom_re     <= start_tbl;                            // RULE3
            o_stack_push <= start_tbl;                            // RULE5
            o_stack_pop  <= (st_r == NAS_ST_LOAD);                // RULE5
            o_busy       <= (st_nxt != NAS_ST_IDLE);
            o_skip       <= active && alu_bus.skip_res;           // RULE8
        end
    end

    assign o_acc       = acc_r;
    assign o_aux       = aux_r;
    assign o_carry     = carry_r;
    assign o_table_ptr = tptr_r;

    // Checks
    a_skip_freezes_acc: assert property (@(posedge i_clk) disable iff (i_rst)
        (executing && skip_pend_r) |=> $stable(acc_r) && $stable(carry_r))
        else $error("skipped slot changed state"); // RULE19
    a_load_chain_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (executing && chain_load && !skip_pend_r) |=> $stable(acc_r))
        else $error("chained load changed acc"); // RULE2
    a_load_imm_acc: assert property (@(posedge i_clk) disable iff (i_rst)
        (active && i_op == nas_pkg::NAS_OP_LOAD_IMM) |=> acc_r == $past(i_imm))
        else $error("load_immediate wrong"); // RULE1
    sequence s_tbl_start;
        start_tbl;
    endsequence
    sequence s_tbl_done;
        ##2 (st_r == NAS_ST_LOAD) ##1 (st_r == NAS_ST_IDLE);
    endsequence
    a_table_timing: assert property (@(posedge i_clk) disable iff (i_rst)
        s_tbl_start |-> s_tbl_done)
        else $error("table lookup timing"); // RULE5
    a_table_push: assert property (@(posedge i_clk) disable iff (i_rst)
        start_tbl |=> o_stack_push ##2 o_stack_pop)
        else $error("stack level not held"); // RULE5
    a_skip_cz: assert property (@(posedge i_clk) disable iff (i_rst)
        (active && i_op == nas_pkg::NAS_OP_SKIP_CZ) |=>
        (o_skip == !$past(carry_r)) && $stable(carry_r))
        else $error("carry skip wrong"); // RULE13
    a_add_mem_carry: assert property (@(posedge i_clk) disable iff (i_rst)
        (active && i_op == nas_pkg::NAS_OP_ADD_MEM) |=> $stable(carry_r))
        else $error("add_memory touched carry"); // RULE6
    a_ror_carry: assert property (@(posedge i_clk) disable iff (i_rst)
        (active && i_op == nas_pkg::NAS_OP_ROR) |=>
        carry_r == $past(acc_r[0]) && acc_r[3] == $past(carry_r))
        else $error("rotate wrong"); // RULE15
    a_set_carry: assert property (@(posedge i_clk) disable iff (i_rst)
        (active && i_op == nas_pkg::NAS_OP_SET_C) |=> carry_r && $stable(acc_r))
        else $error("set carry wrong"); // RULE11
endmodule

// >>> testbench/nas_partner_model.sv
// Purpose: Program ROM table port and data memory nibble at the pointer.
// Assumes: ROM word is valid only in the cycle after a read strobe.
// Notes:   The bench preloads the memory nibble through i_ld.
`timescale 1ns/10ps
module nas_partner_model #(
    parameter int AW = 14
) (
    // Clock, reset and bench preload
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    input  wire logic          i_ld,
    input  wire logic [3:0]    i_ld_val,
    // Data memory side
    input  wire logic          i_mem_we,
    input  wire logic [3:0]    i_mem_wdata,
    output logic      [3:0]    o_mem_rdata,
    // ROM side
    input  wire logic [AW-1:0] i_rom_addr,
    input  wire logic          i_rom_re,
    output logic      [9:0]    o_rom_data
);
    logic [3:0] mem_r;
    logic [9:0] rom_r;

    // Table contents derived from the low eight address bits, so words differ only when those bits differ
    function automatic logic [9:0] rom_word(input logic [AW-1:0] a);
        return {a[1:0] ^ 2'h2, ~a[3:0], a[7:4] ^ a[3:0]};
    endfunction

    assign o_mem_rdata = mem_r;
    assign o_rom_data  = rom_r;

    // Outside its one valid cycle the word toggles, so stale use shows
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mem_r <= 4'h0;
            rom_r <= 10'h0;
        end else begin
            if (i_ld) mem_r <= i_ld_val;
            else if (i_mem_we) mem_r <= i_mem_wdata;
            if (i_rom_re) rom_r <= rom_word(i_rom_addr);
            else rom_r <= ~rom_r;
        end
    end
endmodule

// >>> testbench/testbench.sv
// Purpose: Self-checking bench for the nibble ALU and skip logic.
// Assumes: One op per slot with an idle cycle between slots.
// Notes:   Expected values are worked out here from the op semantics.
`timescale 1ns/10ps
module testbench;
    logic             clk, rst, vld, utf, ld;
    nas_pkg::nas_op_e op;
    logic [3:0]       imm, ld_val, mem_rd, mem_wd, acc, aux;
    logic [6:0]       page;
    logic [13:0]      rom_addr;
    logic [9:0]       rom_d, w;
    logic             mem_we, rom_re, push, pop, busy, skip, carry;
    logic [2:0]       ptr, eptr;
    int               err_count, n_checks;

    nas_core nas_core_i (.i_clk(clk), .i_rst(rst), .i_op_valid(vld),
        .i_op(op), .i_imm(imm), .i_page(page), .i_upper_table_flag(utf),
        .i_mem_rdata(mem_rd), .o_mem_wdata(mem_wd), .o_mem_we(mem_we),
        .o_rom_addr(rom_addr), .o_rom_re(rom_re), .i_rom_data(rom_d),
        .o_stack_push(push), .o_stack_pop(pop), .o_busy(busy),
        .o_skip(skip), .o_acc(acc), .o_aux(aux), .o_carry(carry),
        .o_table_ptr(ptr));

    nas_partner_model nas_partner_model_i (.i_clk(clk), .i_rst(rst),
        .i_ld(ld), .i_ld_val(ld_val), .i_mem_we(mem_we),
        .i_mem_wdata(mem_wd), .o_mem_rdata(mem_rd), .i_rom_addr(rom_addr),
        .i_rom_re(rom_re), .o_rom_data(rom_d));

    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask

    // One slot, then an idle cycle so valid never toggles twice at once
    task automatic issue(input nas_pkg::nas_op_e o, input logic [3:0] n);
        @(posedge clk);
        #1 vld = 1'b1;
        op = o;
        imm = n;
        @(posedge clk);
        #1 vld = 1'b0;
    endtask

    task automatic mem_set(input logic [3:0] v);
        @(posedge clk);
        #1 ld = 1'b1;
        ld_val = v;
        @(posedge clk);
        #1 ld = 1'b0;
    endtask

    task automatic t_load;
        issue(nas_pkg::NAS_OP_LOAD_IMM, 4'h5);
        chk(acc, 16'h5);
        issue(nas_pkg::NAS_OP_LOAD_IMM, 4'h9);
        chk(acc, 16'h5);
        issue(nas_pkg::NAS_OP_CPL, 4'h0);
        chk(acc, 16'ha);
    endtask

    task automatic t_add;
        mem_set(4'h9);
        issue(nas_pkg::NAS_OP_LOAD_IMM, 4'h7);
        issue(nas_pkg::NAS_OP_CLR_C, 4'h0);
        issue(nas_pkg::NAS_OP_ADD_MEM, 4'h0);
        chk({acc, 3'h0, carry}, 16'h00);
        issue(nas_pkg::NAS_OP_LOAD_IMM, 4'h8);
        issue(nas_pkg::NAS_OP_SET_C, 4'h0);
        chk({acc, 3'h0, carry}, 16'h81);
        issue(nas_pkg::NAS_OP_ADD_MEM_C, 4'h0);
        chk({acc, 3'h0, carry}, 16'h21);
        issue(nas_pkg::NAS_OP_ADD_IMM, 4'h3);
        chk({acc, 3'h0, skip, 3'h0, carry}, 16'h511);
        issue(nas_pkg::NAS_OP_CPL, 4'h0);
        chk(acc, 16'h5);
        issue(nas_pkg::NAS_OP_ADD_IMM, 4'hf);
        chk({acc, 3'h0, skip, 3'h0, carry}, 16'h401);
    endtask

    task automatic t_logic;
        issue(nas_pkg::NAS_OP_AND, 4'h0);
        chk(acc, 16'h0);
        issue(nas_pkg::NAS_OP_LOAD_IMM, 4'hc);
        issue(nas_pkg::NAS_OP_OR, 4'h0);
        issue(nas_pkg::NAS_OP_CLR_C, 4'h0);
        chk({acc, 3'h0, carry}, 16'hd0);
        issue(nas_pkg::NAS_OP_ROR, 4'h0);
        chk({acc, 3'h0, carry}, 16'h61);
        issue(nas_pkg::NAS_OP_ROR, 4'h0);
        chk({acc, 3'h0, carry}, 16'hb0);
        issue(nas_pkg::NAS_OP_SKIP_CZ, 4'h0);
        chk({skip, 3'h0, carry}, 16'h10);
        issue(nas_pkg::NAS_OP_SET_C, 4'h0);
        chk(carry, 16'h0);
        issue(nas_pkg::NAS_OP_SET_C, 4'h0);
        issue(nas_pkg::NAS_OP_SKIP_CZ, 4'h0);
        chk({skip, 3'h0, carry}, 16'h01);
    endtask

    // Every bit index, with a skipped write in between
    task automatic t_bits;
        for (int j = 0; j < 4; j++) begin
            mem_set(4'h5);
            issue(nas_pkg::NAS_OP_SET_BIT, 4'(j));
            chk({mem_we, mem_wd}, {12'h1, 4'h5 | (4'h1 << j)});
            issue(nas_pkg::NAS_OP_CLR_BIT, 4'(j));
            chk({mem_we, mem_wd}, {12'h1, 4'h5 & ~(4'h1 << j)});
            issue(nas_pkg::NAS_OP_SKIP_BZ, 4'(j));
            chk(skip, 16'h1);
            issue(nas_pkg::NAS_OP_SET_BIT, 4'(j));
            chk({mem_we, mem_rd}, {12'h0, 4'h5 & ~(4'h1 << j)});
            issue(nas_pkg::NAS_OP_SET_BIT, 4'(j));
            issue(nas_pkg::NAS_OP_SKIP_BZ, 4'(j));
            chk(skip, 16'h0);
        end
    endtask

    task automatic t_table(input logic f);
        logic [13:0] a;
        a = {page, eptr, acc};
        utf = f;
        issue(nas_pkg::NAS_OP_TABLE, 4'h0);
        chk({rom_re, push, busy}, 16'h7);
        chk(rom_addr, 16'(a));
        @(posedge clk);
        #1 chk(busy, 16'h1);
        @(posedge clk);
        #1 w = nas_partner_model_i.rom_word(a);
        if (f) eptr = {1'b0, w[9:8]};
        chk({pop, busy}, 16'h2);
        chk({aux, acc}, 16'(w[7:0]));
        chk(ptr, 16'(eptr));
    endtask

    task automatic wrap_up;
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Watchdog: the sequence needs well under two thousand cycles
    initial begin
        #100000;
        err_count++;
        wrap_up();
    end

    initial begin
        {rst, vld, utf, ld} = 4'h8;
        op = nas_pkg::NAS_OP_NONE;
        {imm, ld_val, page, eptr} = '0;
        err_count = 0;
        n_checks = 0;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        chk({acc, aux, ptr, carry}, 16'h0);
        t_load();
        t_add();
        t_logic();
        t_bits();
        issue(nas_pkg::NAS_OP_LOAD_IMM, 4'h6);
        page = 7'h15;
        t_table(1'b1);
        t_table(1'b0);
        wrap_up();
    end
endmodule
